// ==== reset_partner.sv ====
// reset pin source, watchdog and reset vector memory for the bench
`timescale 1ns/100ps
`include "system_reset_controller_params.svh"
module reset_partner (
  input  wire logic        pclk,
  input  wire logic        vector_fetch,
  input  wire logic [15:0] vector_addr,
  output logic             reset_pin_n,
  output logic             watchdog_overflow,
  output logic             vector_valid,
  output logic [7:0]       vector_data
);
  logic [15:0] vec_word  = 16'h0000;
  int          delay     = 0;
  int          wait_cnt  = 0;
  logic [15:0] seen_addr = 16'h0000;
  logic [7:0]  last_data = 8'h00;

  // pin is low from power-up until the first release
  initial begin
    reset_pin_n       = 1'b0;
    watchdog_overflow = 1'b0;
  end

  // never shorter than the recognised minimum low time
  task automatic pin_reset(input int cycles);
    int n;
    n = (cycles < `MIN_PIN_LOW_CYC) ? `MIN_PIN_LOW_CYC : cycles;
    @(posedge pclk);
    reset_pin_n <= 1'b0;
    repeat (n) @(posedge pclk);
    reset_pin_n <= 1'b1;
  endtask

  // one-cycle overflow report from the runaway detector
  task automatic wdt_pulse();
    @(posedge pclk);
    watchdog_overflow <= 1'b1;
    @(posedge pclk);
    watchdog_overflow <= 1'b0;
  endtask

  // slow memory: a new address restarts the wait before data is offered
  always @(posedge pclk) begin
    if (!vector_fetch || vector_addr != seen_addr) begin
      wait_cnt  <= 0;
      seen_addr <= vector_addr;
    end else if (wait_cnt < delay) begin
      wait_cnt <= wait_cnt + 1;
    end
    if (vector_valid) begin
      last_data <= vector_data;
    end
  end

  assign vector_valid = vector_fetch && vector_addr == seen_addr
                        && wait_cnt >= delay;

  // idle data is the inverse of the last good byte, so a stale byte is never mistaken for a good one
  always_comb begin
    if (vector_valid && vector_addr == `VECTOR_ADDR_LO) begin
      vector_data = vec_word[7:0];
    end else if (vector_valid && vector_addr == `VECTOR_ADDR_HI) begin
      vector_data = vec_word[15:8];
    end else begin
      vector_data = ~last_data;
    end
  end
endmodule // reset_partner

// ==== system_reset_controller.sv ====
// system reset sequencer with apb status/control and reset value vector
`timescale 1ns/100ps
`include "system_reset_controller_params.svh"
module system_reset_controller
  import system_reset_controller_pkg::*;
#(
  parameter int SETTLE_BASE_CYC = 256, // settle cycles at selector 0, doubled per selector step
  parameter int SETTLE_MAX_SEL  = 7
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        reset_pin_n,
  input  wire logic        watchdog_overflow,
  input  wire logic        osc_running,
  input  wire logic        vector_valid,
  input  wire logic [7:0]  vector_data,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             system_reset,
  output logic             pins_hiz,
  output logic             cpu_start,
  output logic [15:0]      program_counter,
  output logic             vector_fetch,
  output logic [15:0]      vector_addr,
  output logic             hold_stop_state,
  output reset_values_s    reset_values
);
  // base shifted by up to 15 must still fit the 32-bit counter
  if (SETTLE_BASE_CYC < 1 || SETTLE_BASE_CYC > 65536 ||
      SETTLE_MAX_SEL < 0 || SETTLE_MAX_SEL > 15) begin : g_bad_params
    $error("unsupported settle parameters");
  end

  localparam int CNT_W = 32;

  // settle length from the selector value, saturated to the legal range
  function automatic logic [CNT_W-1:0] settle_cycles(input logic [7:0] sel);
    logic [3:0] s;
    s = (sel > 8'(SETTLE_MAX_SEL)) ? 4'(SETTLE_MAX_SEL) : sel[3:0];
    settle_cycles = CNT_W'(SETTLE_BASE_CYC) << s;
  endfunction

  // synchroniser: first stage read only by the second
  logic pin_meta;
  logic pin_sync;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else if (clk_en) begin
      pin_meta <= reset_pin_n;
      pin_sync <= pin_meta;
    end
  end

  // sequencer state
  seq_state_e       state;
  seq_state_e       next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             stop_mode;
  logic             next_stop_mode;
  logic             sw_reset;
  logic             next_sw_reset;
  logic [7:0]       osc_sel;
  logic [7:0]       next_osc_sel;
  logic [15:0]      next_pc;
  logic             vec_hi;
  logic             next_vec_hi;
  logic             rst_req;
  logic [1:0]       cause;
  logic [1:0]       next_cause;
  logic             acc;

  // watchdog and pin requests merge into one identical request
  assign rst_req = !pin_sync || watchdog_overflow || sw_reset;

  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_pc        = program_counter;
    next_vec_hi    = vec_hi;
    next_cause     = cause;
    next_stop_mode = stop_mode;
    case (state)
      st_reset: begin
        // watchdog request is a pulse, so it clears itself
        if (!rst_req) begin
          next_state = st_settle;
          next_cnt   = settle_cycles(osc_sel);
        end
      end
      st_settle: begin
        // the count only runs once the oscillator is up again
        if (rst_req) begin
          next_state = st_reset;
        end else if (osc_running) begin
          if (cnt <= CNT_W'(1)) begin
            next_state     = st_vector;
            next_vec_hi    = 1'b0;
            next_stop_mode = 1'b0;
          end else begin
            next_cnt = cnt - CNT_W'(1);
          end
        end
      end
      st_vector: begin
        if (rst_req) begin
          next_state = st_reset;
        end else if (vector_valid) begin
          if (!vec_hi) begin
            next_pc[7:0] = vector_data;
            next_vec_hi  = 1'b1;
          end else begin
            next_pc[15:8] = vector_data;
            next_state    = st_run;
          end
        end
      end
      st_run: begin
        if (rst_req) begin
          next_state = st_reset;
        end
        if (acc && pwrite && paddr == `OFS_CONTROL) begin
          next_stop_mode = pwdata[`CTRL_BIT_STOP];
        end
      end
      default: next_state = st_reset;
    endcase
    if (rst_req) begin
      next_cause = {watchdog_overflow || sw_reset, !pin_sync};
    end
  end

  // program counter cleared only by presetn; a reset request leaves it as is, it is only meaningful after fetch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state           <= st_reset;
      cnt             <= '0;
      program_counter <= 16'h0000;
      vec_hi          <= 1'b0;
      cause           <= 2'b00;
    end else if (clk_en) begin
      state           <= next_state;
      cnt             <= next_cnt;
      program_counter <= next_pc;
      vec_hi          <= next_vec_hi;
      cause           <= next_cause;
    end
  end

  // reset value image; stack, ram and register bank have none
  reset_values_s rv_const;
  always_comb begin
    rv_const                       = '0;
    rv_const.processor_status_word = `RST_PSW;
    rv_const.port_latch            = `RST_LATCH;
    rv_const.port_dir              = `RST_DIR;
    rv_const.pullup_option_zero    = `RST_PULLUP;
    rv_const.cpu_clock_ctrl        = `RST_CPU_CLK;
    rv_const.suboscillator_mode    = `RST_ZERO8;
    rv_const.subclock_ctrl         = `RST_ZERO8;
    rv_const.osc_settle_select     = `RST_OSC_SEL;
    rv_const.wide_timer_count      = `RST_ZERO16;
    rv_const.wide_timer_compare    = `RST_ONES16;
    rv_const.wide_timer_mode       = `RST_ZERO8;
    rv_const.buzzer_ctrl           = `RST_ZERO8;
    rv_const.narrow_timer_count    = `RST_ZERO8;
    rv_const.narrow_timer_mode     = `RST_ZERO8;
    rv_const.carrier_out_ctrl      = `RST_ZERO8;
    rv_const.watch_timer_mode      = `RST_ZERO8;
    rv_const.watchdog_clock_select = `RST_ZERO8;
    rv_const.watchdog_mode         = `RST_ZERO8;
    rv_const.serial_mode           = `RST_ZERO8;
    rv_const.serial_status         = `RST_ZERO8;
    rv_const.serial_baud           = `RST_ZERO8;
    rv_const.serial_tx_shift       = `RST_TX_SHIFT;
    rv_const.adc_result            = `RST_ZERO16;
    rv_const.adc_mode              = `RST_ZERO8;
    rv_const.adc_channel           = `RST_ZERO8;
    rv_const.display_mode          = `RST_ZERO8;
    rv_const.display_clock         = `RST_ZERO8;
    rv_const.display_boost_ctrl    = `RST_ZERO8;
    rv_const.irq_flag_low          = `RST_ZERO8;
    rv_const.irq_flag_high         = `RST_ZERO8;
    rv_const.irq_mask_low          = `RST_IRQ_MASK;
    rv_const.irq_mask_high         = `RST_IRQ_MASK;
    rv_const.ext_irq_mode          = `RST_ZERO8;
    rv_const.key_return_mode       = `RST_ZERO8;
  end

  // apb slave: read word latched in setup so it stands through access,
  // writes land at the access edge; error on unmapped offsets
  logic        setup;
  logic        hit;
  logic [31:0] rd_word;
  logic [31:0] next_prdata;
  assign setup = psel && !penable;
  assign acc   = psel && penable;
  always_comb begin
    next_sw_reset = sw_reset;
    next_osc_sel  = osc_sel;
    next_prdata   = prdata;
    rd_word       = 32'h0000_0000;
    hit           = 1'b1;
    // software reset request holds until the sequencer is in st_reset, unlike the one-cycle watchdog pulse
    if (state == st_reset) begin
      next_sw_reset = 1'b0;
    end
    case (paddr)
      `OFS_CONTROL: begin
        rd_word = {30'h0, sw_reset, stop_mode};
        if (acc && pwrite) begin
          next_sw_reset = pwdata[`CTRL_BIT_SW_RESET];
        end
      end
      `OFS_STATUS:
        rd_word = {24'h0, cause, 2'b00, state};
      `OFS_VECTOR:
        rd_word = {16'h0, program_counter};
      `OFS_SETTLE: begin
        rd_word = {24'h0, osc_sel};
        if (acc && pwrite && state == st_run) begin
          next_osc_sel = pwdata[7:0];
        end
      end
      default:
        hit = 1'b0;
    endcase
    // any reset cause restores the selector, even over a late write
    if (rst_req) begin
      next_osc_sel = `RST_OSC_SEL;
    end
    if (setup) begin
      next_prdata = rd_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_reset  <= 1'b0;
      osc_sel   <= `RST_OSC_SEL;
      stop_mode <= 1'b0;
      prdata    <= 32'h0000_0000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
    end else if (clk_en) begin
      sw_reset  <= next_sw_reset;
      osc_sel   <= next_osc_sel;
      stop_mode <= next_stop_mode;
      prdata    <= next_prdata;
      pready    <= psel && !penable;
      pslverr   <= setup && !hit;
    end
  end

  // registered outputs of the sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_reset    <= 1'b1;
      pins_hiz        <= 1'b1;
      cpu_start       <= 1'b0;
      vector_fetch    <= 1'b0;
      vector_addr     <= `VECTOR_ADDR_LO;
      hold_stop_state <= 1'b0;
    end else if (clk_en) begin
      system_reset    <= (next_state == st_reset);
      pins_hiz        <= (next_state == st_reset) ||
                         (next_state == st_settle);
      cpu_start       <= (next_state == st_run);
      vector_fetch    <= (next_state == st_vector);
      vector_addr     <= next_vec_hi ? `VECTOR_ADDR_HI
                                     : `VECTOR_ADDR_LO;
      hold_stop_state <= next_stop_mode &&
                         (next_state != st_run);
    end
  end

  // image has no reset of its own: it reloads the constants at every
  // enabled edge, so it already stands when presetn lets go
  always_ff @(posedge pclk) begin
    if (clk_en) begin
      reset_values <= rv_const;
    end
  end

  // pins float in every enabled reset cycle
  property p_hiz_in_reset;
    @(posedge pclk) disable iff (!presetn)
      clk_en && system_reset |-> pins_hiz;
  endproperty
  a_hiz_in_reset: assert property (p_hiz_in_reset)
    else $error("pins not floating during reset");

  property p_no_run_in_settle;
    @(posedge pclk) disable iff (!presetn)
      state == st_settle |-> !cpu_start;
  endproperty
  a_no_run_in_settle: assert property (p_no_run_in_settle)
    else $error("cpu started before settle");

  property p_wdt_resets;
    @(posedge pclk) disable iff (!presetn)
      clk_en && watchdog_overflow |=> state == st_reset;
  endproperty
  a_wdt_resets: assert property (p_wdt_resets)
    else $error("watchdog overflow did not reset");

  property p_psw_value;
    @(posedge pclk) disable iff (!presetn)
      system_reset |-> reset_values.processor_status_word == 8'h02;
  endproperty
  a_psw_value: assert property (p_psw_value)
    else $error("status word reset value wrong");

  property p_settle_after_reset;
    @(posedge pclk) disable iff (!presetn)
      clk_en && state == st_reset && !rst_req |=> state == st_settle;
  endproperty
  a_settle_after_reset: assert property (p_settle_after_reset)
    else $error("no settle after reset release");

  property p_run_after_vec;
    @(posedge pclk) disable iff (!presetn)
      $rose(cpu_start) |-> $past(vector_addr) == 16'h0001;
  endproperty
  a_run_after_vec: assert property (p_run_after_vec)
    else $error("start without high vector byte");

  property p_osc_gate;
    @(posedge pclk) disable iff (!presetn)
      clk_en && state == st_settle && !osc_running && !rst_req
        |=> state == st_settle && $stable(cnt);
  endproperty
  a_osc_gate: assert property (p_osc_gate)
    else $error("settle counted without oscillator");

  property p_masks;
    @(posedge pclk) disable iff (!presetn)
      cpu_start |-> reset_values.irq_mask_low == 8'hFF &&
                    reset_values.port_dir == 8'hFF;
  endproperty
  a_masks: assert property (p_masks)
    else $error("mask or direction reset value wrong");

  c_pin_reset:  cover property (@(posedge pclk) $fell(pin_sync));
  c_wdt_reset:  cover property (@(posedge pclk) watchdog_overflow);
  c_run:        cover property (@(posedge pclk) $rose(cpu_start));
endmodule // system_reset_controller

// ==== system_reset_controller_params.svh ====
// constants for the system reset controller
`ifndef SYSTEM_RESET_CONTROLLER_PARAMS_SVH
`define SYSTEM_RESET_CONTROLLER_PARAMS_SVH
`define OFS_CONTROL        12'h000
`define OFS_STATUS         12'h004
`define OFS_VECTOR         12'h008
`define OFS_SETTLE         12'h00C
`define VECTOR_ADDR_LO     16'h0000
`define VECTOR_ADDR_HI     16'h0001
`define RST_PSW            8'h02
`define RST_LATCH          8'h00
`define RST_DIR            8'hFF
`define RST_PULLUP         8'h00
`define RST_CPU_CLK        8'h02
`define RST_OSC_SEL        8'h04
`define RST_ZERO8          8'h00
`define RST_ZERO16         16'h0000
`define RST_ONES16         16'hFFFF
`define RST_TX_SHIFT       8'hFF
`define RST_IRQ_MASK       8'hFF
`define MIN_PIN_LOW_NS     10000
`define CLK_PERIOD_NS      8
`define MIN_PIN_LOW_CYC    ((`MIN_PIN_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CTRL_BIT_STOP      0
`define CTRL_BIT_SW_RESET  1
`endif

// ==== system_reset_controller_pkg.sv ====
// types for the system reset controller
package system_reset_controller_pkg;
  typedef enum logic [3:0] {
    st_reset  = 4'b0001,
    st_settle = 4'b0010,
    st_vector = 4'b0100,
    st_run    = 4'b1000
  } seq_state_e;
  typedef struct packed {
    logic [7:0]  processor_status_word;
    logic [7:0]  port_latch;
    logic [7:0]  port_dir;
    logic [7:0]  pullup_option_zero;
    logic [7:0]  cpu_clock_ctrl;
    logic [7:0]  suboscillator_mode;
    logic [7:0]  subclock_ctrl;
    logic [7:0]  osc_settle_select;
    logic [15:0] wide_timer_count;
    logic [15:0] wide_timer_compare;
    logic [7:0]  wide_timer_mode;
    logic [7:0]  buzzer_ctrl;
    logic [7:0]  narrow_timer_count;
    logic [7:0]  narrow_timer_mode;
    logic [7:0]  carrier_out_ctrl;
    logic [7:0]  watch_timer_mode;
    logic [7:0]  watchdog_clock_select;
    logic [7:0]  watchdog_mode;
    logic [7:0]  serial_mode;
    logic [7:0]  serial_status;
    logic [7:0]  serial_baud;
    logic [7:0]  serial_tx_shift;
    logic [15:0] adc_result;
    logic [7:0]  adc_mode;
    logic [7:0]  adc_channel;
    logic [7:0]  display_mode;
    logic [7:0]  display_clock;
    logic [7:0]  display_boost_ctrl;
    logic [7:0]  irq_flag_low;
    logic [7:0]  irq_flag_high;
    logic [7:0]  irq_mask_low;
    logic [7:0]  irq_mask_high;
    logic [7:0]  ext_irq_mode;
    logic [7:0]  key_return_mode;
  } reset_values_s;
endpackage

// ==== system_reset_controller_tb.sv ====
// self-checking bench for the system reset controller
`timescale 1ns/100ps
`include "system_reset_controller_params.svh"
module system_reset_controller_tb
  import system_reset_controller_pkg::*;
();
  localparam int BASE       = 1;
  localparam int SETTLE_EXP = BASE << 4; // settle select resets to 04H
  localparam int LIMIT      = 20000;
  localparam int W          = $bits(reset_values_s);
  logic          pclk        = 1'b0;
  logic          presetn     = 1'b0;
  logic          clk_en      = 1'b1;
  logic          osc_running = 1'b1;
  logic          psel        = 1'b0;
  logic          penable     = 1'b0;
  logic          pwrite      = 1'b0;
  logic [11:0]   paddr       = 12'h000;
  logic [31:0]   pwdata      = 32'h00000000;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic          system_reset;
  logic          pins_hiz;
  logic          cpu_start;
  logic [15:0]   program_counter;
  logic          vector_fetch;
  logic [15:0]   vector_addr;
  logic          hold_stop_state;
  reset_values_s reset_values;
  logic          reset_pin_n;
  logic          watchdog_overflow;
  logic          vector_valid;
  logic [7:0]    vector_data;
  logic [31:0]   seed        = 32'hB32C;
  logic          armed       = 1'b0;
  int            miscompares = 0;
  int            checks      = 0;
  int            cyc         = 0;

  system_reset_controller #(.SETTLE_BASE_CYC(BASE), .SETTLE_MAX_SEL(7)) dut_u (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .reset_pin_n(reset_pin_n), .watchdog_overflow(watchdog_overflow),
    .osc_running(osc_running), .vector_valid(vector_valid),
    .vector_data(vector_data), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .system_reset(system_reset),
    .pins_hiz(pins_hiz), .cpu_start(cpu_start),
    .program_counter(program_counter), .vector_fetch(vector_fetch),
    .vector_addr(vector_addr), .hold_stop_state(hold_stop_state),
    .reset_values(reset_values));

  reset_partner model_u (
    .pclk(pclk), .vector_fetch(vector_fetch), .vector_addr(vector_addr),
    .reset_pin_n(reset_pin_n), .watchdog_overflow(watchdog_overflow),
    .vector_valid(vector_valid), .vector_data(vector_data));

  always #4 pclk = ~pclk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction

  // image after reset; every field not named here must read zero
  function automatic reset_values_s exp_image();
    reset_values_s r;
    r = '0;
    r.processor_status_word = 8'h02;
    r.port_dir              = 8'hFF;
    r.cpu_clock_ctrl        = 8'h02;
    r.osc_settle_select     = 8'h04;
    r.wide_timer_compare    = 16'hFFFF;
    r.serial_tx_shift       = 8'hFF;
    r.irq_mask_low          = 8'hFF;
    r.irq_mask_high         = 8'hFF;
    return r;
  endfunction

  task automatic chk(input string n, input logic [W-1:0] e,
                     input logic [W-1:0] g);
    checks++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // apb master: setup, then access held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // counts settle cycles, stalling the oscillator or the enable midway
  task automatic wait_run(input int stall, input logic on_osc,
                          output int settle);
    int n;
    settle = 0;
    n = 0;
    while (cpu_start !== 1'b1 && n < 4000) begin
      @(posedge pclk);
      n++;
      if (system_reset === 1'b0 && vector_fetch === 1'b0
          && cpu_start === 1'b0) begin
        settle++;
        chk("pins_hiz settle", 1, pins_hiz);
        if (settle == 3 && stall > 0 && on_osc) osc_running <= 1'b0;
        if (settle == 3 && stall > 0 && !on_osc) clk_en <= 1'b0;
        if (settle == 3 + stall) begin
          osc_running <= 1'b1;
          clk_en      <= 1'b1;
        end
      end
    end
  endtask

  // the reset image must stand through reset and settle
  always @(posedge pclk) begin
    cyc++;
    if (armed && (system_reset === 1'b1 || pins_hiz === 1'b1))
      chk("reset_values", exp_image(), reset_values);
    if (cyc == LIMIT) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    logic [31:0] q;
    logic        e;
    int          settle;
    int          cause;
    int          stall;
    int          n;
    logic        stop;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    armed = 1'b1;
    // causes: 0 pin, 1 watchdog, 2 software; first three fixed
    for (int i = 0; i < 7; i++) begin
      seed = lfsr(seed);
      cause = (i < 3) ? i : int'(seed % 32'd3);
      stall = int'(seed[3:2]);
      model_u.vec_word = seed[23:8];
      model_u.delay = int'(seed[1:0]);
      stop = (cause == 0 && i > 0);
      if (stop) apb(1'b1, `OFS_CONTROL, 32'h00000001, q, e);
      if (cause == 0) model_u.pin_reset(`MIN_PIN_LOW_CYC + seed[6:4]);
      else if (cause == 1) model_u.wdt_pulse();
      else apb(1'b1, `OFS_CONTROL, 32'h00000002, q, e);
      n = 0;
      while (system_reset !== 1'b1 && n < 4) begin
        @(posedge pclk);
        n++;
      end
      chk("system_reset", 1, system_reset);
      chk("pins_hiz reset", 1, pins_hiz);
      if (stop) chk("hold_stop_state", 1, hold_stop_state);
      if (cause == 0) begin
        @(posedge pclk);
        chk("sync delay", 1, system_reset);
      end
      wait_run(stall, seed[7], settle);
      chk("settle", SETTLE_EXP + stall, settle);
      chk("program_counter", seed[23:8], program_counter);
      chk("pins_hiz run", 0, pins_hiz);
      chk("hold_stop_state run", 0, hold_stop_state);
      apb(1'b0, `OFS_STATUS, 32'h00000000, q, e);
      chk("state", 4'b1000, q[3:0]);
      chk("cause", (cause == 0) ? 2'b01 : 2'b10, q[7:6]);
      apb(1'b0, `OFS_VECTOR, 32'h00000000, q, e);
      chk("vector reg", seed[23:8], q[15:0]);
      apb(1'b0, `OFS_SETTLE, 32'h00000000, q, e);
      chk("settle select", 8'h04, q[7:0]);
      // a changed select must be undone by the next reset
      apb(1'b1, `OFS_SETTLE, {30'h0, seed[9:8]}, q, e);
      apb(1'b0, `OFS_SETTLE, 32'h00000000, q, e);
      chk("settle write", seed[9:8], q[7:0]);
      apb(1'b0, 12'h010, 32'h00000000, q, e);
      chk("unmapped err", 1, e);
      chk("unmapped data", 0, q);
    end
    give_verdict();
  end
endmodule // system_reset_controller_tb
